/* icg_pkg.sv */
// constants for the i2c condition generator and receive filter
`default_nettype none
package icg_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  // length of one condition phase, in ns, per the chosen bus timing
  localparam int unsigned PHASE_TIME_NS   = 5000;
  localparam int unsigned PHASE_CYCLES    =
    (PHASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PHASE_CNT_W     = 16;
  // default ratio of internal clock to filter sample tick
  localparam int unsigned SAMPLE_DIV      = 1;
  // ---------------------------------------------------------------
  // reset values and filter depth
  // ---------------------------------------------------------------
  localparam logic        PIN_IDLE_RST    = 1'b1;
  localparam logic        FILT_RST        = 1'b1;
  localparam int unsigned FILT_STAGES     = 3;

  typedef enum logic [2:0] {
    ICG_IDLE, ICG_PREP, ICG_SETUP, ICG_HOLD, ICG_DONE
  } icg_state_t;

  typedef enum logic [1:0] {
    ICG_C_START, ICG_C_RESTART, ICG_C_STOP
  } icg_cond_t;
endpackage
`default_nettype wire

/* icg_rx_filter.sv */
// three-latch all-agree noise filter for the receive data input
`default_nettype none
module icg_rx_filter #(
  parameter int unsigned STAGES = 3
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sample_tick,
  input  wire logic din,
  output var  logic dout
);
  initial begin
    if (STAGES != 3) $error("icg_rx_filter needs exactly three stages");
  end

  logic [2:0] lat_q;
  logic       out_q;
  wire        all_hi = &lat_q;
  wire        all_lo = ~|lat_q;

  // three cascaded latches sampled on the 16x tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lat_q <= {3{icg_pkg::FILT_RST}};
      out_q <= icg_pkg::FILT_RST;
    end else if (sample_tick) begin
      lat_q <= {lat_q[1:0], din};
      // agreement passes the level, disagreement holds it
      if (all_hi) out_q <= 1'b1;
      else if (all_lo) out_q <= 1'b0;
    end
  end
  assign dout = out_q;

  agree_hi_a: assert property (@(posedge clk) disable iff (!nrst)
    (sample_tick && all_hi) |=> out_q)
    else $error("filter failed to pass agreeing high");
  agree_lo_a: assert property (@(posedge clk) disable iff (!nrst)
    (sample_tick && all_lo) |=> !out_q)
    else $error("filter failed to pass agreeing low");
  disagree_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (!(sample_tick && (all_hi || all_lo))) |=> $stable(out_q))
    else $error("filter output moved without agreement");
endmodule
`default_nettype wire

/* icg_top.sv */
// i2c start/restart/stop generator with filtered receive input
//
// Contract
// - start request plus select makes start
// - restart request plus select makes restart
// - stop request plus select makes stop
// - select low passes transfer clock, data
// - select high drives conditions from requests
// - interrupt on detect (sel 0), done (1)
// - filter enable routes receive through filter
// - filter is three cascaded latches plus match
// - latches sample on 16x bit clock
// - all three equal passes the level
// - disagreement holds, rejects short glitches
`default_nettype none
module icg_top #(
  parameter int unsigned PHASE_CYC  = icg_pkg::PHASE_CYCLES,
  parameter int unsigned SAMPLE_DIV = icg_pkg::SAMPLE_DIV
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start_request,
  input  wire logic repeated_start_request,
  input  wire logic stop_request,
  input  wire logic condition_output_select,
  input  wire logic rx_filter_enable,
  input  wire logic xfer_scl,
  input  wire logic xfer_sda,
  input  wire logic serial_clock_pin_i,
  input  wire logic serial_data_pin_i,
  input  wire logic receive_data_input,
  output var  logic serial_clock_pin_o,
  output var  logic serial_clock_pin_oe,
  output var  logic serial_data_pin_o,
  output var  logic serial_data_pin_oe,
  output var  logic cond_irq,
  output var  logic cond_busy,
  output var  logic rx_data
);
  initial begin
    // two cycles of prep at least: scl must fall before sda moves
    if (PHASE_CYC < 2 || PHASE_CYC >= (1 << icg_pkg::PHASE_CNT_W))
      $error("icg_top: PHASE_CYC out of range");
    if (SAMPLE_DIV < 1 || SAMPLE_DIV > 256)
      $error("icg_top: SAMPLE_DIV out of range");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q, rxd_s_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      rxd_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[0], serial_clock_pin_i};
      sda_s_q <= {sda_s_q[0], serial_data_pin_i};
      rxd_s_q <= {rxd_s_q[0], receive_data_input};
    end
  end
  wire scl_s = scl_s_q[1];
  wire sda_s = sda_s_q[1];
  wire rxd_s = rxd_s_q[1];

  // ---------------------------------------------------------------
  // receive filter
  // ---------------------------------------------------------------
  // the block clock stands in for the 16x basic clock; a divider
  // makes the sample tick so the rate can be matched to the baud
  logic [7:0] div_q;
  wire        div_end = (div_q == 8'(SAMPLE_DIV - 1));
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) div_q <= 8'h00;
    else div_q <= div_end ? 8'h00 : div_q + 8'h01;
  end

  logic rxd_filt;
  icg_rx_filter #(.STAGES(icg_pkg::FILT_STAGES)) u_filt (
    .clk        (clk),
    .nrst       (nrst),
    .sample_tick(div_end),
    .din        (rxd_s),
    .dout       (rxd_filt)
  );

  logic rx_q;
  wire  rx_d = rx_filter_enable ? rxd_filt : rxd_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rx_q <= icg_pkg::FILT_RST;
    else rx_q <= rx_d;
  end
  assign rx_data = rx_q;

  // ---------------------------------------------------------------
  // condition generator
  // ---------------------------------------------------------------
  // requests are assumed stable before select rises in
  // slave use both stay low so the fsm never leaves idle
  icg_pkg::icg_state_t st_q, st_d;
  icg_pkg::icg_cond_t  cond_q, cond_d;
  logic [15:0] cnt_q;
  logic        gscl_q, gsda_q, done_q;
  wire         cnt_end = (cnt_q == 16'(PHASE_CYC - 1));
  wire         any_req = start_request | repeated_start_request |
                         stop_request;
  wire         go = condition_output_select && any_req &&
                    (st_q == icg_pkg::ICG_IDLE);

  // start wins over restart over stop when several are set
  assign cond_d = start_request          ? icg_pkg::ICG_C_START   :
                  repeated_start_request ? icg_pkg::ICG_C_RESTART :
                                           icg_pkg::ICG_C_STOP;

  always_comb begin
    st_d = st_q;
    case (st_q)
      icg_pkg::ICG_IDLE:  if (go) st_d = icg_pkg::ICG_PREP;
      icg_pkg::ICG_PREP:  if (cnt_end) st_d = icg_pkg::ICG_SETUP;
      icg_pkg::ICG_SETUP: if (cnt_end) st_d = icg_pkg::ICG_HOLD;
      icg_pkg::ICG_HOLD:  if (cnt_end) st_d = icg_pkg::ICG_DONE;
      icg_pkg::ICG_DONE:  if (!condition_output_select)
                            st_d = icg_pkg::ICG_IDLE;
      default:            st_d = icg_pkg::ICG_IDLE;
    endcase
  end

  // prep: put sda at its pre level with scl low (restart/stop) or
  // keep both high (start); setup: scl high; hold: move sda
  wire is_stop  = (cond_q == icg_pkg::ICG_C_STOP);
  wire is_rst   = (cond_q == icg_pkg::ICG_C_RESTART);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= icg_pkg::ICG_IDLE;
      cond_q <= icg_pkg::ICG_C_START;
      cnt_q  <= 16'h0000;
      gscl_q <= icg_pkg::PIN_IDLE_RST;
      gsda_q <= icg_pkg::PIN_IDLE_RST;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= (st_d != st_q || cnt_end) ? 16'h0000 : cnt_q + 16'h0001;
      done_q <= (st_q == icg_pkg::ICG_HOLD) && cnt_end;
      if (go) cond_q <= cond_d;
      case (st_q)
        icg_pkg::ICG_IDLE: begin
          // track the transfer lines so select can rise without a step
          // and no stale level of the last condition shows up
          gscl_q <= xfer_scl;
          gsda_q <= xfer_sda;
        end
        icg_pkg::ICG_PREP: begin
          gscl_q <= !(is_stop || is_rst);
          // for restart/stop sda moves only once scl is low, else a false condition
          if (!gscl_q || !(is_stop || is_rst)) gsda_q <= !is_stop;
        end
        icg_pkg::ICG_SETUP: gscl_q <= 1'b1;
        icg_pkg::ICG_HOLD:  if (cnt_end) gsda_q <= is_stop;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin mux and condition interrupt
  // ---------------------------------------------------------------
  // open drain: drive only lows; the enable carries the level
  wire sel_gen = condition_output_select;
  wire scl_val = sel_gen ? gscl_q : xfer_scl;
  wire sda_val = sel_gen ? gsda_q : xfer_sda;

  logic scl_oe_q, sda_oe_q, irq_q, busy_q, scl_p_q, sda_p_q;
  wire  det_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire  det_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;
  wire  irq_d = sel_gen ? done_q : (det_start || det_stop);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      irq_q   <= 1'b0;
      busy_q  <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_oe_q <= ~scl_val;
      sda_oe_q <= ~sda_val;
      irq_q   <= irq_d;
      busy_q  <= (st_d != icg_pkg::ICG_IDLE) &&
                 (st_d != icg_pkg::ICG_DONE);
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign serial_clock_pin_o  = 1'b0;
  assign serial_data_pin_o   = 1'b0;
  assign serial_clock_pin_oe = scl_oe_q;
  assign serial_data_pin_oe  = sda_oe_q;
  assign cond_irq  = irq_q;
  assign cond_busy = busy_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // cycles since the generator was started; the sequence is too long
  // for a delay range, so a counter watches it instead
  logic [17:0] gen_age_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) gen_age_q <= 18'h0_0000;
    else gen_age_q <= go ? 18'h0_0000 : gen_age_q + 18'h0_0001;
  end

  sequence hold_phase_s;
    (st_q == icg_pkg::ICG_HOLD) && cnt_end;
  endsequence
  gen_start_a: assert property (@(posedge clk) disable iff (!nrst)
    (busy_q && cond_q == icg_pkg::ICG_C_START) |->
      (gen_age_q < 18'(3 * PHASE_CYC)))
    else $error("start condition not reached");
  sda_edge_a: assert property (@(posedge clk) disable iff (!nrst)
    hold_phase_s |=> (gscl_q && gsda_q == is_stop))
    else $error("sda moved with scl low");
  pass_through_a: assert property (@(posedge clk) disable iff (!nrst)
    !sel_gen |=> (scl_oe_q == !$past(xfer_scl)))
    else $error("transfer clock not passed");
  gen_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    sel_gen |=> (sda_oe_q == !$past(gsda_q)))
    else $error("generated data not driven");
  irq_done_a: assert property (@(posedge clk) disable iff (!nrst)
    (sel_gen && done_q) |=> cond_irq)
    else $error("completion interrupt missing");
  rx_route_a: assert property (@(posedge clk) disable iff (!nrst)
    rx_filter_enable |=> (rx_data == $past(rxd_filt)))
    else $error("filtered receive not routed");
  rx_raw_a: assert property (@(posedge clk) disable iff (!nrst)
    !rx_filter_enable |=> (rx_data == $past(rxd_s)))
    else $error("raw receive not routed");
  stop_gen_a: assert property (@(posedge clk) disable iff (!nrst)
    (hold_phase_s and is_stop) |=> ##1 done_q == 1'b0)
    else $error("stop completion pulse too long");
endmodule
`default_nettype wire

/* icg_bus_partner.sv */
// i2c bus partner: open-drain pulls and a small master frame
`default_nettype none
module icg_bus_partner (
  output var logic scl_pull,
  output var logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
  end
  // 48 ns link clock, only inside the frame; data moves while
  // the clock is low, so only the framing edges look like
  // conditions
  task automatic frame(input logic [3:0] bits);
    sda_pull = 1'h1;
    #24 scl_pull = 1'h1;
    for (int i = 3; i >= 0; i--) begin
      #12 sda_pull = !bits[i];
      #12 scl_pull = 1'h0;
      #24 scl_pull = 1'h1;
    end
    #12 sda_pull = 1'h1;
    #12 scl_pull = 1'h0;
    #24 sda_pull = 1'h0;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the condition generator and rx filter
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PC = 4;
  logic clk, nrst, st, rs, sp, sel, fen, xscl, xsda, rxd;
  wire logic scl_oe, sda_oe, irq, busy, rx, p_scl, p_sda;
  wire logic scl_w, sda_w, scl_o, sda_o;
  int        err_count, check_count, irq_n, busy_n, low_n;
  // -------------------------------------------------------
  // wiring: pull-ups on both lines, wired-and of all pulls
  // -------------------------------------------------------
  assign scl_w = (scl_oe ? scl_o : 1'h1) & ~p_scl;
  assign sda_w = (sda_oe ? sda_o : 1'h1) & ~p_sda;
  icg_top #(.PHASE_CYC(PC), .SAMPLE_DIV(1)) dut (
    .clk(clk), .nrst(nrst), .start_request(st),
    .repeated_start_request(rs), .stop_request(sp),
    .condition_output_select(sel), .rx_filter_enable(fen),
    .xfer_scl(xscl), .xfer_sda(xsda),
    .serial_clock_pin_i(scl_w), .serial_data_pin_i(sda_w),
    .receive_data_input(rxd), .serial_clock_pin_o(scl_o),
    .serial_clock_pin_oe(scl_oe), .serial_data_pin_o(sda_o),
    .serial_data_pin_oe(sda_oe), .cond_irq(irq),
    .cond_busy(busy), .rx_data(rx));
  icg_bus_partner bus (.scl_pull(p_scl), .sda_pull(p_sda));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (irq === 1'h1) irq_n <= irq_n + 1;
    if (busy === 1'h1) busy_n <= busy_n + 1;
    if (rx === 1'h0) low_n <= low_n + 1;
  end
  // -------------------------------------------------------
  // tasks
  // -------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the seen value is taken at the call; the compare waits 1 ns past it
  task automatic chk(input string nm, input logic e, input logic g);
    #1;
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic gen(input int k, input logic e_sda);
    int n, b, t;
    n = irq_n;
    b = busy_n;
    t = 0;
    @(posedge clk);
    st <= (k == 0);
    rs <= (k == 1);
    sp <= (k == 2);
    @(posedge clk);
    sel <= 1'h1;
    while (irq_n == n && t < 200) begin
      @(posedge clk);
      t++;
    end
    if (t >= 200) begin
      err_count++;
      $display("mismatch irq expected pulse seen none");
      conclude();
    end
    repeat (2) @(posedge clk);
    chk("busy", 1'h1, busy_n != b);
    chk("latency", 1'h1, t >= 3 * PC);
    chk("scl", 1'h1, scl_w);
    chk("sda", e_sda, sda_w);
    @(posedge clk);
    sel <= 1'h0;
    {st, rs, sp} <= 3'h0;
    repeat (12) @(posedge clk);
  endtask
  task automatic pass_thru();
    for (int v = 0; v < 4; v++) begin
      @(posedge clk);
      xscl <= v[1];
      xsda <= v[0];
      repeat (4) @(posedge clk);
      chk("pass_scl", v[1], scl_w);
      chk("pass_sda", v[0], sda_w);
    end
    repeat (12) @(posedge clk);
  endtask
  // slave-like use: requests and select stay low
  task automatic detect();
    int n;
    n = irq_n;
    bus.frame(4'h5);
    repeat (8) @(posedge clk);
    chk("detect_irq", 1'h1, irq_n - n == 2);
  endtask
  task automatic filt(input logic en, input int w, input logic e);
    int n;
    n = low_n;
    @(posedge clk);
    fen <= en;
    repeat (4) @(posedge clk);
    rxd <= 1'h0;
    repeat (w) @(posedge clk);
    rxd <= 1'h1;
    repeat (10) @(posedge clk);
    chk("rx_low", e, low_n != n);
  endtask
  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    {st, rs, sp, sel, fen} = 5'h00;
    {xscl, xsda, rxd} = 3'h7;
    {err_count, check_count, irq_n, busy_n, low_n} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    gen(0, 1'h0);
    gen(1, 1'h0);
    gen(2, 1'h1);
    pass_thru();
    detect();
    filt(1'h1, 2, 1'h0);
    filt(1'h1, 3, 1'h1);
    filt(1'h0, 1, 1'h1);
    conclude();
  end
endmodule
`default_nettype wire
